/* src/cmpb_pkg.sv */
package cmpb_pkg;

    // ----------------------------------------------------------------
    // register addresses on the special-function register bus
    // ----------------------------------------------------------------
    localparam logic [7:0] CMPB_CTRL_ADDR = 8'h9A;
    localparam logic [7:0] CMPB_MODE_ADDR = 8'h9C;
    localparam logic [7:0] CMPB_INSEL_ADDR = 8'h9E;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] CMPB_CTRL_RESET = 8'h00;
    localparam logic [7:0] CMPB_MODE_RESET = 8'h02;
    localparam logic [7:0] CMPB_INSEL_RESET = 8'h00;
    localparam logic [1:0] CMPB_SPEED_RESET = 2'h2;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    // comparator_b_control
    localparam int CMPB_ON_BIT = 7;
    localparam int CMPB_RESULT_BIT = 6;
    localparam int CMPB_RISE_FLAG_BIT = 5;
    localparam int CMPB_FALL_FLAG_BIT = 4;
    localparam int CMPB_POS_HYST_LSB = 2;
    localparam int CMPB_NEG_HYST_LSB = 0;
    // comparator_b_mode
    localparam int CMPB_RISE_IE_BIT = 5;
    localparam int CMPB_FALL_IE_BIT = 4;
    localparam int CMPB_SPEED_LSB = 0;
    // input_select_register
    localparam int CMPB_MINUS_SEL_LSB = 4;
    localparam int CMPB_PLUS_SEL_LSB = 0;
    localparam int CMPB_SEL_WIDTH = 3;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    // hysteresis codes: off, 5 mV, 10 mV, 20 mV
    typedef enum logic [1:0] {
        CMPB_HYST_OFF,
        CMPB_HYST_5MV,
        CMPB_HYST_10MV,
        CMPB_HYST_20MV
    } cmpb_hyst_type;

    // response speed: fastest/highest power down to slowest/lowest power
    typedef enum logic [1:0] {
        CMPB_SPEED_FAST,
        CMPB_SPEED_MID1,
        CMPB_SPEED_MID2,
        CMPB_SPEED_SLOW
    } cmpb_speed_type;

    // one access on the special-function register bus
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cmpb_sfr_req_type;

    // settings handed to the analog comparator core
    typedef struct packed {
        logic on;
        cmpb_hyst_type pos_hyst;
        cmpb_hyst_type neg_hyst;
        cmpb_speed_type speed;
        logic [2:0] plus_sel;
        logic [2:0] minus_sel;
    } cmpb_analog_cfg_type;

endpackage

/* src/cmpb_edge_flag.sv */
`timescale 1ns/1ps
module cmpb_edge_flag (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // hardware event and software access
    input wire logic event_in,
    input wire logic wr_in,
    input wire logic wdata_in,
    // sticky flag
    output logic flag_out
);

    logic flag_reg;
    logic flag_next;

    // the event wins over a software clear in the same cycle
    assign flag_next = event_in | (wr_in ? wdata_in : flag_reg);

    // sticky flag storage
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_out = flag_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_event_beats_clear;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (event_in && wr_in && !wdata_in) |=> flag_reg;
    endproperty
    a_event_beats_clear: assert property (p_event_beats_clear)
        else $error("edge event lost to a simultaneous clear");

    property p_flag_sticky;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (flag_reg && !wr_in) |=> flag_reg;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("edge flag dropped without a software write");

endmodule

/* src/cmpb_ctrl_regs.sv */
`timescale 1ns/1ps
module cmpb_ctrl_regs (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // special-function register bus
    input wire cmpb_pkg::cmpb_sfr_req_type sfr_req_in,
    output logic [7:0] sfr_rdata_out,
    // analog comparator core
    input wire logic cmp_raw_in,
    output cmpb_pkg::cmpb_analog_cfg_type analog_cfg_out,
    // port routing and interrupt
    output logic cmp_port_out,
    output logic irq_out
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n_reg;

    // assertion is immediate, release is held back two edges
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire ctrl_hit = sfr_req_in.addr == cmpb_pkg::CMPB_CTRL_ADDR;
    wire mode_hit = sfr_req_in.addr == cmpb_pkg::CMPB_MODE_ADDR;
    wire insel_hit = sfr_req_in.addr == cmpb_pkg::CMPB_INSEL_ADDR;
    wire ctrl_wr = sfr_req_in.wr & ctrl_hit;
    wire mode_wr = sfr_req_in.wr & mode_hit;
    wire insel_wr = sfr_req_in.wr & insel_hit;
    wire [7:0] wdata = sfr_req_in.wdata;

    // ----------------------------------------------------------------
    // writable fields
    // ----------------------------------------------------------------
    logic comparator_on_reg;
    logic [1:0] pos_hysteresis_sel_reg;
    logic [1:0] neg_hysteresis_sel_reg;
    logic rise_irq_enable_reg;
    logic fall_irq_enable_reg;
    logic [1:0] response_speed_sel_reg;
    logic [2:0] plus_input_select_reg;
    logic [2:0] minus_input_select_reg;

    always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            comparator_on_reg <= cmpb_pkg::CMPB_CTRL_RESET[cmpb_pkg::CMPB_ON_BIT];
            pos_hysteresis_sel_reg <= 2'h0;
            neg_hysteresis_sel_reg <= 2'h0;
        end else if (ctrl_wr) begin
            comparator_on_reg <= wdata[cmpb_pkg::CMPB_ON_BIT];
            pos_hysteresis_sel_reg <= wdata[cmpb_pkg::CMPB_POS_HYST_LSB +: 2];
            neg_hysteresis_sel_reg <= wdata[cmpb_pkg::CMPB_NEG_HYST_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rise_irq_enable_reg <= 1'b0;
            fall_irq_enable_reg <= 1'b0;
            response_speed_sel_reg <= cmpb_pkg::CMPB_SPEED_RESET;
        end else if (mode_wr) begin
            rise_irq_enable_reg <= wdata[cmpb_pkg::CMPB_RISE_IE_BIT];
            fall_irq_enable_reg <= wdata[cmpb_pkg::CMPB_FALL_IE_BIT];
            response_speed_sel_reg <= wdata[cmpb_pkg::CMPB_SPEED_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            plus_input_select_reg <= 3'h0;
            minus_input_select_reg <= 3'h0;
        end else if (insel_wr) begin
            plus_input_select_reg <= wdata[cmpb_pkg::CMPB_PLUS_SEL_LSB +: 3];
            minus_input_select_reg <= wdata[cmpb_pkg::CMPB_MINUS_SEL_LSB +: 3];
        end
    end

    // ----------------------------------------------------------------
    // comparator result and edges
    // ----------------------------------------------------------------
    logic compare_result_reg;
    logic result_prev_reg;
    logic cmp_port_reg;
    wire rise_event;
    wire fall_event;
    logic rise_seen_flag;
    logic fall_seen_flag;

    // port forced low
    // a powered-down core has no meaningful output, so the result reads 0
    always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            compare_result_reg <= 1'b0;
            result_prev_reg <= 1'b0;
            cmp_port_reg <= 1'b0;
        end else begin
            compare_result_reg <= comparator_on_reg & cmp_raw_in;
            result_prev_reg <= compare_result_reg;
            cmp_port_reg <= comparator_on_reg & cmp_raw_in;
        end
    end

    // edges count only while running; the forced low of a disable is no edge
    assign rise_event = comparator_on_reg & compare_result_reg & ~result_prev_reg;
    assign fall_event = comparator_on_reg & ~compare_result_reg & result_prev_reg;

    cmpb_edge_flag u_rise_flag (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_reg),
        .event_in(rise_event),
        .wr_in(ctrl_wr),
        .wdata_in(wdata[cmpb_pkg::CMPB_RISE_FLAG_BIT]),
        .flag_out(rise_seen_flag)
    );

    cmpb_edge_flag u_fall_flag (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_reg),
        .event_in(fall_event),
        .wr_in(ctrl_wr),
        .wdata_in(wdata[cmpb_pkg::CMPB_FALL_FLAG_BIT]),
        .flag_out(fall_seen_flag)
    );

    // ----------------------------------------------------------------
    // interrupt
    // ----------------------------------------------------------------
    logic irq_reg;
    wire irq_next;

    assign irq_next = (rise_seen_flag & rise_irq_enable_reg)
                    | (fall_seen_flag & fall_irq_enable_reg);

    always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    wire [7:0] ctrl_view = {comparator_on_reg, compare_result_reg, rise_seen_flag,
                            fall_seen_flag, pos_hysteresis_sel_reg, neg_hysteresis_sel_reg};
    wire [7:0] mode_view = {2'h0, rise_irq_enable_reg, fall_irq_enable_reg,
                            2'h0, response_speed_sel_reg};
    wire [7:0] insel_view = {1'b0, minus_input_select_reg, 1'b0, plus_input_select_reg};
    // unmapped addresses read zero
    wire [7:0] read_value = ctrl_hit ? ctrl_view :
                            mode_hit ? mode_view :
                            insel_hit ? insel_view : 8'h00;
    logic [7:0] rdata_reg;

    // read data is captured on the read strobe and held until the next one
    always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rdata_reg <= 8'h00;
        end else if (sfr_req_in.rd) begin
            rdata_reg <= read_value;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // enable, hysteresis codes, speed code and pin selects to the core
    assign analog_cfg_out = '{
        on: comparator_on_reg,
        pos_hyst: cmpb_pkg::cmpb_hyst_type'(pos_hysteresis_sel_reg),
        neg_hyst: cmpb_pkg::cmpb_hyst_type'(neg_hysteresis_sel_reg),
        speed: cmpb_pkg::cmpb_speed_type'(response_speed_sel_reg),
        plus_sel: plus_input_select_reg,
        minus_sel: minus_input_select_reg
    };
    assign cmp_port_out = cmp_port_reg;
    assign irq_out = irq_reg;
    assign sfr_rdata_out = rdata_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_enable_write;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        ctrl_wr |=> analog_cfg_out.on == $past(wdata[cmpb_pkg::CMPB_ON_BIT]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable bit did not follow the control write");

    property p_port_low_off;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        (!comparator_on_reg && !ctrl_wr) |=> ##1 !cmp_port_out;
    endproperty
    a_port_low_off: assert property (p_port_low_off)
        else $error("port output high while comparator disabled");

    property p_result_tracks;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        comparator_on_reg |=> compare_result_reg == $past(cmp_raw_in);
    endproperty
    a_result_tracks: assert property (p_result_tracks)
        else $error("result bit does not follow the core output");

    property p_rise_sets;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        (comparator_on_reg && !ctrl_wr && $rose(compare_result_reg)) |=> rise_seen_flag;
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("rising edge did not set its flag");

    property p_fall_sets;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        (comparator_on_reg && !ctrl_wr && $fell(compare_result_reg)) |=> fall_seen_flag;
    endproperty
    a_fall_sets: assert property (p_fall_sets)
        else $error("falling edge did not set its flag");

    property p_pos_hyst;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        ctrl_wr |=> analog_cfg_out.pos_hyst == $past(wdata[3:2]);
    endproperty
    a_pos_hyst: assert property (p_pos_hyst)
        else $error("positive hysteresis code not applied");

    property p_neg_hyst;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        ctrl_wr |=> analog_cfg_out.neg_hyst == $past(wdata[1:0]);
    endproperty
    a_neg_hyst: assert property (p_neg_hyst)
        else $error("negative hysteresis code not applied");

    property p_rise_irq;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        (rise_seen_flag && rise_irq_enable_reg) |=> irq_out;
    endproperty
    a_rise_irq: assert property (p_rise_irq)
        else $error("enabled rising flag did not raise the interrupt");

    property p_fall_irq;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        (fall_seen_flag && fall_irq_enable_reg) |=> irq_out;
    endproperty
    a_fall_irq: assert property (p_fall_irq)
        else $error("enabled falling flag did not raise the interrupt");

    property p_speed;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        mode_wr |=> analog_cfg_out.speed == $past(wdata[1:0]);
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed code not applied");

    property p_unused_zero;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        (sfr_req_in.rd && mode_hit) |=> (sfr_rdata_out[7:6] == 2'h0)
                                        && (sfr_rdata_out[3:2] == 2'h0);
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused mode bits read nonzero");

    property p_plus_sel;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        insel_wr |=> analog_cfg_out.plus_sel == $past(wdata[2:0]);
    endproperty
    a_plus_sel: assert property (p_plus_sel)
        else $error("plus pin select not applied");

    property p_minus_sel;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        insel_wr |=> analog_cfg_out.minus_sel == $past(wdata[6:4]);
    endproperty
    a_minus_sel: assert property (p_minus_sel)
        else $error("minus pin select not applied");

    property p_irq_quiet;
        @(posedge clk_sys_in) disable iff (!rst_n_reg)
        !((rise_seen_flag && rise_irq_enable_reg) || (fall_seen_flag && fall_irq_enable_reg))
        |=> !irq_out;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt high with no enabled flag set");

    c_rise_flag: cover property (@(posedge clk_sys_in) disable iff (!rst_n_reg)
        rise_event ##1 rise_seen_flag);
    c_fall_flag: cover property (@(posedge clk_sys_in) disable iff (!rst_n_reg)
        fall_event ##1 fall_seen_flag);
    c_irq: cover property (@(posedge clk_sys_in) disable iff (!rst_n_reg)
        $rose(irq_out));
    c_disable: cover property (@(posedge clk_sys_in) disable iff (!rst_n_reg)
        $fell(comparator_on_reg) ##1 !cmp_port_out);

endmodule

/* bench/cmpb_core_model.sv */
`timescale 1ns/1ps
// analog core stand-in: follows the commanded level after a delay set by the speed code
module cmpb_core_model (
    // clock
    input wire logic clk_sys_in,
    // settings from the block and level wanted by the bench
    input wire cmpb_pkg::cmpb_analog_cfg_type cfg_in,
    input wire logic level_in,
    // raw comparator output
    output logic raw_out
);
    logic [3:0] hist_reg;
    logic tog_reg;

    // slower speed codes answer later, as a real core would
    // plain always: the initial block below also gives these a start value
    always @(posedge clk_sys_in) begin
        hist_reg <= {hist_reg[2:0], level_in};
        tog_reg <= ~tog_reg;
    end

    initial begin
        hist_reg = 4'h0;
        tog_reg = 1'b0;
    end

    // an unpowered core gives no trustworthy level, so it chatters every cycle
    assign raw_out = cfg_in.on ? hist_reg[cfg_in.speed] : tog_reg;
endmodule

/* bench/cmpb_ctrl_regs_tb.sv */
`timescale 1ns/1ps
module cmpb_ctrl_regs_tb;
    logic clk_sys_in;
    logic arst_n_in;
    cmpb_pkg::cmpb_sfr_req_type req;
    logic [7:0] rdata;
    logic raw;
    logic level;
    logic port;
    logic irq;
    cmpb_pkg::cmpb_analog_cfg_type cfg;
    int miscompares;
    int n_checks;

    cmpb_ctrl_regs cmpb_ctrl_regs_i (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .sfr_req_in(req),
        .sfr_rdata_out(rdata),
        .cmp_raw_in(raw),
        .analog_cfg_out(cfg),
        .cmp_port_out(port),
        .irq_out(irq)
    );

    cmpb_core_model cmpb_core_model_i (
        .clk_sys_in(clk_sys_in),
        .cfg_in(cfg),
        .level_in(level),
        .raw_out(raw)
    );

    // 25 MHz system clock
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask

    // inputs move 1 ns after the rising edge so every sample is settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        cyc(1);
        req.wr = 1'b0;
        cyc(1);
    endtask

    // read data is registered, so it is ready once the strobe edge has passed;
    // an idle edge follows so a back-to-back request never rewrites the strobe at once
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        cyc(1);
        req.rd = 1'b0;
        check(name, rdata, exp);
        cyc(1);
    endtask

    task automatic wait_port(input logic v);
        int i;
        for (i = 0; i < 20; i++) begin
            if (port === v) break;
            cyc(1);
        end
        if (i == 20) begin
            check("port wait", 8'h00, 8'h01);
            complete_run();
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd_chk("ctrl rst", cmpb_pkg::CMPB_CTRL_ADDR, 8'h00);
        rd_chk("mode rst", cmpb_pkg::CMPB_MODE_ADDR, 8'h02);
        rd_chk("insel rst", cmpb_pkg::CMPB_INSEL_ADDR, 8'h00);
        check("speed rst", {6'h00, cfg.speed}, 8'h02);
        wr(8'h9B, 8'hFF);
        rd_chk("unmapped", 8'h9B, 8'h00);
        rd_chk("ctrl kept", cmpb_pkg::CMPB_CTRL_ADDR, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_fields();
        logic [1:0] k;
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            wr(cmpb_pkg::CMPB_CTRL_ADDR, {4'h0, k, ~k});
            check("pos hyst", {6'h00, cfg.pos_hyst}, {6'h00, k});
            check("neg hyst", {6'h00, cfg.neg_hyst}, {6'h00, ~k});
            wr(cmpb_pkg::CMPB_MODE_ADDR, {6'h3F, k});
            check("speed", {6'h00, cfg.speed}, {6'h00, k});
            rd_chk("mode rd", cmpb_pkg::CMPB_MODE_ADDR, {6'h0C, k});
        end
        wr(cmpb_pkg::CMPB_MODE_ADDR, 8'hCC);
        rd_chk("mode unused", cmpb_pkg::CMPB_MODE_ADDR, 8'h00);
        // result bit cannot be written while off
        wr(cmpb_pkg::CMPB_CTRL_ADDR, 8'h40);
        rd_chk("ctrl ro", cmpb_pkg::CMPB_CTRL_ADDR, 8'h00);
        wr(cmpb_pkg::CMPB_INSEL_ADDR, 8'h35);
        check("plus sel", {5'h00, cfg.plus_sel}, 8'h05);
        check("minus sel", {5'h00, cfg.minus_sel}, 8'h03);
        wr(cmpb_pkg::CMPB_INSEL_ADDR, 8'hFF);
        rd_chk("insel rd", cmpb_pkg::CMPB_INSEL_ADDR, 8'h77);
        $display("test fields done");
    endtask

    task automatic t_edges();
        level = 1'b0;
        wr(cmpb_pkg::CMPB_MODE_ADDR, 8'h00);
        cyc(4);
        check("port off", {7'h00, port}, 8'h00);
        wr(cmpb_pkg::CMPB_CTRL_ADDR, 8'h80);
        check("cfg on", {7'h00, cfg.on}, 8'h01);
        cyc(4);
        // power-up may leave false edges behind, so both flags are cleared
        wr(cmpb_pkg::CMPB_CTRL_ADDR, 8'h80);
        level = 1'b1;
        wait_port(1'b1);
        // this clear lands on the very edge of the rising event: the event must win
        wr(cmpb_pkg::CMPB_CTRL_ADDR, 8'h80);
        rd_chk("rise", cmpb_pkg::CMPB_CTRL_ADDR, 8'hE0);
        check("irq masked", {7'h00, irq}, 8'h00);
        wr(cmpb_pkg::CMPB_MODE_ADDR, 8'h20);
        cyc(1);
        check("irq rise", {7'h00, irq}, 8'h01);
        level = 1'b0;
        wait_port(1'b0);
        cyc(2);
        rd_chk("fall", cmpb_pkg::CMPB_CTRL_ADDR, 8'hB0);
        wr(cmpb_pkg::CMPB_CTRL_ADDR, 8'h90);
        cyc(1);
        check("irq fall masked", {7'h00, irq}, 8'h00);
        rd_chk("fall sticky", cmpb_pkg::CMPB_CTRL_ADDR, 8'h90);
        wr(cmpb_pkg::CMPB_MODE_ADDR, 8'h10);
        cyc(1);
        check("irq fall", {7'h00, irq}, 8'h01);
        wr(cmpb_pkg::CMPB_CTRL_ADDR, 8'h80);
        cyc(1);
        check("irq clear", {7'h00, irq}, 8'h00);
        $display("test edges done");
    endtask

    task automatic t_disable();
        level = 1'b1;
        wait_port(1'b1);
        cyc(3);
        wr(cmpb_pkg::CMPB_CTRL_ADDR, 8'h80);
        // the core chatters while off; none of it may reach flags or the port
        wr(cmpb_pkg::CMPB_CTRL_ADDR, 8'h00);
        for (int i = 0; i < 6; i++) begin
            check("port dis", {7'h00, port}, 8'h00);
            cyc(1);
        end
        rd_chk("ctrl dis", cmpb_pkg::CMPB_CTRL_ADDR, 8'h00);
        check("irq dis", {7'h00, irq}, 8'h00);
        $display("test disable done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        miscompares = 0;
        n_checks = 0;
        arst_n_in = 1'b0;
        level = 1'b0;
        req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        cyc(16);
        arst_n_in = 1'b1;
        cyc(3);
        t_reset();
        t_fields();
        t_edges();
        t_disable();
        complete_run();
    end
endmodule
